// [logic/atp_timer.sv]
// 8-bit timer/counter with prescaler, compare output, phase-correct pwm and async crystal clock
`timescale 1ns/1ps

// Overview of operation
// - clock select picks stop, undivided, or divide by 8,32,64,128,256,1024
// - after a counter write, counting resumes from that value next timer tick
// - 8-bit read/write counter, up normally, up/down in pwm mode
// - compare match only by counting; a write making equality gives no match
// - compare flag sets in the cpu cycle after the compare event
// - pwm counts 0 up to 255 and back down to 0, continuously
// - pwm modes: 0x disconnected, 10 non-inverted, 11 inverted output
// - pwm compare writes latch into effective compare only at counter top
// - compare reads return the most recently written value
// - effective compare at 0 or 255 forces the pwm output at once
// - pwm overflow flag sets when the counter leaves zero
// - interrupts requested when flag, own enable and global enable all set
// - pwm period is 510 timer ticks
// - async select bit clocks timer from crystal pin and claims crystal pins
// - async writes set per-register busy flags, cleared when destination loads
// - async holding register reaches destination after two crystal rising edges
// - counter reads are live; compare and control reads return holding values
// - status bits 7..4 read zero, busy bits read-only, select bit read/write
// - compare pin driven only when the port direction bit selects output
module atp_timer
    import atp_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // avalon-mm register slave, word addressed
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // pins
    input  wire logic        crystal_clock_pin,
    input  wire logic        port_dir_out,
    output logic             compare_output_pin_o,
    output logic             compare_output_pin_oe_n,
    output logic             crystal_pins_claimed,
    // interrupt requests
    output logic             overflow_irq,
    output logic             compare_irq
);

    // bus state
    logic        waitreq_reg;
    logic [7:0]  rdata_reg;
    // crystal synchroniser
    logic        xtal_meta_reg;
    logic        xtal_sync_reg;
    logic        xtal_prev_reg;
    logic        xtal_rise;
    // software-visible registers with their transfer counts and effective copies
    logic        async_sel_reg;
    logic [2:0]  busy_reg;
    logic [1:0]  xfer_cnt_reg [3];
    atp_ctrl_t   ctrl_hold_reg;
    atp_ctrl_t   ctrl_eff_reg;
    logic [7:0]  count_hold_reg;
    logic [7:0]  cmp_hold_reg;
    logic [7:0]  cmp_dest_reg;
    logic [7:0]  cmp_eff_reg;
    logic [7:0]  flags_reg;
    logic [7:0]  irq_en_reg;
    // counting
    logic [9:0]  presc_reg;
    logic [7:0]  count_reg;
    logic [7:0]  count_next;
    atp_dir_t    dir_reg;
    logic        cmp_evt_reg;
    logic        ovf_evt_reg;
    logic        oc_level_reg;
    logic        oc_oe_n_reg;
    logic        ovf_irq_reg;
    logic        cmp_irq_reg;
    // decoded strobes
    logic        acc_fire;
    logic        wr_fire;
    logic        wr_count;
    logic        wr_compare;
    logic        wr_control;
    logic [2:0]  wr_vec;
    logic [7:0]  wdata;
    logic [2:0]  xfer_done;
    logic        count_load;
    logic        cmp_load;
    logic        ctrl_load;
    logic        tick_base;
    logic        tick;
    logic        match_now;
    logic        up_step;
    logic [9:0]  div_mask;

    // request taken on the cycle after it appears, one wait state
    assign acc_fire   = (avs_read | avs_write) & ~waitreq_reg;
    assign wr_fire    = avs_write & ~waitreq_reg & avs_byteenable[0];
    assign wdata      = avs_writedata[7:0];
    assign wr_count   = wr_fire & (avs_address == COUNT_IDX);
    assign wr_compare = wr_fire & (avs_address == COMPARE_IDX);
    assign wr_control = wr_fire & (avs_address == CONTROL_IDX);
    assign wr_vec     = {wr_count, wr_compare, wr_control};

    // wait state generator
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            waitreq_reg <= 1'b1;
        end else if ((avs_read | avs_write) & waitreq_reg) begin
            waitreq_reg <= 1'b0;
        end else begin
            waitreq_reg <= 1'b1;
        end
    end

    // read data captured one edge before it is sampled; counter is live
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_reg <= BYTE_RESET;
        end else if (avs_read & waitreq_reg) begin
            case (avs_address)
                ASYNC_STATUS_IDX: rdata_reg <= {4'h0, async_sel_reg, busy_reg};
                COUNT_IDX:        rdata_reg <= count_reg;
                COMPARE_IDX:      rdata_reg <= cmp_hold_reg;
                CONTROL_IDX:      rdata_reg <= ctrl_hold_reg;
                FLAGS_IDX:        rdata_reg <= flags_reg;
                IRQ_ENABLE_IDX:   rdata_reg <= irq_en_reg;
                default:          rdata_reg <= BYTE_RESET;
            endcase
        end
    end

    assign avs_readdata    = {24'h000000, rdata_reg};
    assign avs_waitrequest = waitreq_reg;

    // two-flop synchroniser plus edge history for the crystal pin
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            xtal_meta_reg <= 1'b0;
            xtal_sync_reg <= 1'b0;
            xtal_prev_reg <= 1'b0;
        end else begin
            xtal_meta_reg <= crystal_clock_pin;
            xtal_sync_reg <= xtal_meta_reg;
            xtal_prev_reg <= xtal_sync_reg;
        end
    end

    // only the second stage feeds logic; works while crystal is below sys_clk/4
    assign xtal_rise = xtal_sync_reg & ~xtal_prev_reg;

    // async select bit; busy bits are not writable
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            async_sel_reg <= 1'b0;
        end else if (wr_fire & (avs_address == ASYNC_STATUS_IDX)) begin
            async_sel_reg <= wdata[ASYNC_SEL_BIT];
        end
    end

    // holding registers always take the write, so compare and control readback shows the latest value
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count_hold_reg <= BYTE_RESET;
            cmp_hold_reg   <= BYTE_RESET;
            ctrl_hold_reg  <= BYTE_RESET;
        end else begin
            if (wr_count) begin
                count_hold_reg <= wdata;
            end
            if (wr_compare) begin
                cmp_hold_reg <= wdata;
            end
            if (wr_control) begin
                ctrl_hold_reg <= {1'b0, wdata[6:0]};
            end
        end
    end

    // per-register busy flag and crystal edge count; a rewrite while busy restarts it
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            busy_reg <= 3'h0;
            for (int k = 0; k < 3; k++) begin
                xfer_cnt_reg[k] <= 2'h0;
            end
        end else begin
            for (int k = 0; k < 3; k++) begin
                if (wr_vec[k] & async_sel_reg) begin
                    busy_reg[k]     <= 1'b1;
                    xfer_cnt_reg[k] <= 2'h0;
                end else if (xfer_done[k]) begin
                    busy_reg[k]     <= 1'b0;
                    xfer_cnt_reg[k] <= 2'h0;
                end else if (busy_reg[k] & xtal_rise) begin
                    xfer_cnt_reg[k] <= xfer_cnt_reg[k] + 2'h1;
                end
            end
        end
    end

    // transfer completes on the second crystal rising edge
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            xfer_done[k] = busy_reg[k] & xtal_rise & (xfer_cnt_reg[k] == XFER_EDGES - 2'h1);
        end
    end

    // destination loads: direct in sync mode, after transfer in async mode
    assign count_load = async_sel_reg ? xfer_done[COUNT_BUSY_BIT] : wr_count;
    assign cmp_load   = async_sel_reg ? xfer_done[COMPARE_BUSY_BIT] : wr_compare;
    assign ctrl_load  = async_sel_reg ? xfer_done[CONTROL_BUSY_BIT] : wr_control;

    // effective control and compare destination
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_eff_reg <= BYTE_RESET;
            cmp_dest_reg <= BYTE_RESET;
        end else begin
            if (ctrl_load) begin
                ctrl_eff_reg <= async_sel_reg ? ctrl_hold_reg : {1'b0, wdata[6:0]};
            end
            if (cmp_load) begin
                cmp_dest_reg <= async_sel_reg ? cmp_hold_reg : wdata;
            end
        end
    end

    // in pwm the compare used by the counter changes only at top, avoiding glitches
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cmp_eff_reg <= BYTE_RESET;
        end else if (!ctrl_eff_reg.pwm || count_reg == COUNT_TOP) begin
            cmp_eff_reg <= cmp_dest_reg;
        end
    end

    // prescaler input: crystal edges in async mode, every cycle otherwise
    assign tick_base = async_sel_reg ? xtal_rise : 1'b1;
    assign div_mask  = atp_div_mask(ctrl_eff_reg.cs);
    assign tick      = tick_base & (ctrl_eff_reg.cs != CS_STOP)
                       & ((presc_reg & div_mask) == div_mask);

    // free-running prescaler shared by every divide ratio
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            presc_reg <= 10'h000;
        end else if (tick_base) begin
            presc_reg <= presc_reg + 10'h001;
        end
    end

    // next count: plain up count, or up/down turning at the ends in pwm
    always_comb begin
        if (!ctrl_eff_reg.pwm) begin
            count_next = count_reg + 8'h01;
        end else if (dir_reg == ATP_UP) begin
            count_next = (count_reg == COUNT_TOP) ? COUNT_TOP - 8'h01 : count_reg + 8'h01;
        end else begin
            count_next = (count_reg == COUNT_BOT) ? COUNT_BOT + 8'h01 : count_reg - 8'h01;
        end
    end

    assign up_step   = count_next > count_reg;
    // a write never compares; only a counting step can match
    assign match_now = tick & ~count_load & (count_next == cmp_eff_reg);

    // counter register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count_reg <= BYTE_RESET;
        end else if (count_load) begin
            count_reg <= async_sel_reg ? count_hold_reg : wdata;
        end else if (tick) begin
            count_reg <= count_next;
        end
    end

    // count direction for the phase-correct sweep
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dir_reg <= ATP_UP;
        end else if (!ctrl_eff_reg.pwm) begin
            dir_reg <= ATP_UP;
        end else if (tick & ~count_load) begin
            if (dir_reg == ATP_UP && count_reg == COUNT_TOP) begin
                dir_reg <= ATP_DOWN;
            end else if (dir_reg == ATP_DOWN && count_reg == COUNT_BOT) begin
                dir_reg <= ATP_UP;
            end
        end
    end

    // events registered here; flags follow one cycle later
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cmp_evt_reg <= 1'b0;
            ovf_evt_reg <= 1'b0;
        end else begin
            cmp_evt_reg <= match_now;
            ovf_evt_reg <= tick & ~count_load & (ctrl_eff_reg.pwm ? count_reg == COUNT_BOT
                                                                  : count_reg == COUNT_TOP);
        end
    end

    // sticky flags, write one to clear; a same-cycle event wins over the clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flags_reg <= BYTE_RESET;
        end else begin
            if (wr_fire & (avs_address == FLAGS_IDX)) begin
                flags_reg <= flags_reg & ~(wdata & FLAG_MASK);
            end
            if (cmp_evt_reg) begin
                flags_reg[CMP_BIT] <= 1'b1;
            end
            if (ovf_evt_reg) begin
                flags_reg[OVF_BIT] <= 1'b1;
            end
        end
    end

    // individual and global enables
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_en_reg <= BYTE_RESET;
        end else if (wr_fire & (avs_address == IRQ_ENABLE_IDX)) begin
            irq_en_reg <= wdata & ENABLE_MASK;
        end
    end

    // interrupt requests gated by both enables
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ovf_irq_reg <= 1'b0;
            cmp_irq_reg <= 1'b0;
        end else begin
            ovf_irq_reg <= flags_reg[OVF_BIT] & irq_en_reg[OVF_BIT] & irq_en_reg[GIE_BIT];
            cmp_irq_reg <= flags_reg[CMP_BIT] & irq_en_reg[CMP_BIT] & irq_en_reg[GIE_BIT];
        end
    end

    // compare output level; extremes in pwm force the level without a match
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            oc_level_reg <= 1'b0;
        end else if (ctrl_eff_reg.pwm) begin
            if (ctrl_eff_reg.com[1]) begin
                if (cmp_eff_reg == COUNT_BOT) begin
                    oc_level_reg <= ctrl_eff_reg.com[0];
                end else if (cmp_eff_reg == COUNT_TOP) begin
                    oc_level_reg <= ~ctrl_eff_reg.com[0];
                end else if (match_now) begin
                    oc_level_reg <= up_step ? ctrl_eff_reg.com[0] : ~ctrl_eff_reg.com[0];
                end
            end
        end else if (match_now) begin
            case (ctrl_eff_reg.com)
                2'h1:    oc_level_reg <= ~oc_level_reg;
                2'h2:    oc_level_reg <= 1'b0;
                2'h3:    oc_level_reg <= 1'b1;
                default: oc_level_reg <= oc_level_reg;
            endcase
        end
    end

    // pin driven only when connected and the port direction is output
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            oc_oe_n_reg <= 1'b1;
        end else begin
            oc_oe_n_reg <= ~(port_dir_out & (ctrl_eff_reg.pwm ? ctrl_eff_reg.com[1]
                                                              : ctrl_eff_reg.com != 2'h0));
        end
    end

    assign compare_output_pin_o    = oc_level_reg;
    assign compare_output_pin_oe_n = oc_oe_n_reg;
    assign crystal_pins_claimed    = async_sel_reg;
    assign overflow_irq            = ovf_irq_reg;
    assign compare_irq             = cmp_irq_reg;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    stop_holds_a: assert property (
        ctrl_eff_reg.cs == CS_STOP && !count_load |=> count_reg == $past(count_reg))
        else $error("counter moved while stopped");
    write_no_match_a: assert property (
        count_load |=> !cmp_evt_reg)
        else $error("counter write produced a compare event");
    flag_follows_a: assert property (
        cmp_evt_reg |=> flags_reg[CMP_BIT])
        else $error("compare flag not set after event");
    pwm_turn_a: assert property (
        ctrl_eff_reg.pwm && tick && !count_load && count_reg == COUNT_TOP
        |=> count_reg == COUNT_TOP - 8'h01 && dir_reg == ATP_DOWN)
        else $error("pwm did not turn at top");
    latch_at_top_a: assert property (
        ctrl_eff_reg.pwm && $past(ctrl_eff_reg.pwm) && $changed(cmp_eff_reg)
        |-> $past(count_reg) == COUNT_TOP)
        else $error("pwm compare latched away from top");
    pwm_extreme_a: assert property (
        ctrl_eff_reg.pwm && ctrl_eff_reg.com[1] && cmp_eff_reg == COUNT_BOT
        |=> oc_level_reg == $past(ctrl_eff_reg.com[0]))
        else $error("pwm output not forced for zero compare");
    ovf_leave_zero_a: assert property (
        ctrl_eff_reg.pwm && tick && !count_load && count_reg == COUNT_BOT
        |=> ovf_evt_reg ##1 flags_reg[OVF_BIT])
        else $error("overflow not flagged leaving zero");
    irq_gate_a: assert property (
        ovf_irq_reg |-> $past(flags_reg[OVF_BIT] && irq_en_reg[OVF_BIT] && irq_en_reg[GIE_BIT]))
        else $error("overflow request without enables");
    busy_set_a: assert property (
        wr_compare && async_sel_reg |=> busy_reg[COMPARE_BUSY_BIT] [*1] ##0 !cmp_load)
        else $error("async compare write did not set busy");
    two_edges_a: assert property (
        $fell(busy_reg[COUNT_BUSY_BIT]) |-> $past(xtal_rise)
        && $past(xfer_cnt_reg[COUNT_BUSY_BIT]) == XFER_EDGES - 2'h1)
        else $error("counter transfer not on second crystal edge");
    status_reserved_a: assert property (
        avs_read && !waitreq_reg && avs_address == ASYNC_STATUS_IDX |-> rdata_reg[7:4] == 4'h0)
        else $error("reserved status bits not zero");

    pwm_sweep_c: cover property (ctrl_eff_reg.pwm && dir_reg == ATP_DOWN ##[1:600] dir_reg == ATP_UP);
    async_xfer_c: cover property ($rose(busy_reg[CONTROL_BUSY_BIT]) ##[1:200] !busy_reg[CONTROL_BUSY_BIT]);
    match_flag_c: cover property (cmp_evt_reg ##1 flags_reg[CMP_BIT]);
    irq_c: cover property ($rose(compare_irq));

endmodule // atp_timer

// [logic/atp_pkg.sv]
// constants, field layouts and types for the async 8-bit timer with pwm
package atp_pkg;

    // register word indices; byte address is four times the index
    localparam logic [7:0] ASYNC_STATUS_IDX = 8'h22;
    localparam logic [7:0] COMPARE_IDX      = 8'h23;
    localparam logic [7:0] COUNT_IDX        = 8'h24;
    localparam logic [7:0] CONTROL_IDX      = 8'h25;
    localparam logic [7:0] FLAGS_IDX        = 8'h38;
    localparam logic [7:0] IRQ_ENABLE_IDX   = 8'h39;

    // async status bit positions
    localparam int ASYNC_SEL_BIT   = 3;
    localparam int COUNT_BUSY_BIT  = 2;
    localparam int COMPARE_BUSY_BIT = 1;
    localparam int CONTROL_BUSY_BIT = 0;

    // flag and enable bit positions
    localparam int OVF_BIT = 0;
    localparam int CMP_BIT = 1;
    localparam int GIE_BIT = 7;

    // reset values, counter limits and register bit masks
    localparam logic [7:0] BYTE_RESET  = 8'h00;
    localparam logic [7:0] COUNT_TOP   = 8'hFF;
    localparam logic [7:0] COUNT_BOT   = 8'h00;
    localparam logic [7:0] FLAG_MASK   = 8'h03;
    localparam logic [7:0] ENABLE_MASK = 8'h83;
    localparam logic [7:0] STATUS_RW   = 8'h08;

    // clock select codes
    localparam logic [2:0] CS_STOP   = 3'h0;
    localparam logic [2:0] CS_DIRECT = 3'h1;

    // crystal edges before a holding register reaches its destination
    localparam logic [1:0] XFER_EDGES = 2'h2;
    // ticks in one up/down pwm period
    localparam int PWM_PERIOD = 510;

    // control register layout, msb first
    typedef struct packed {
        logic       rsv;
        logic       pwm;
        logic [1:0] com;
        logic       ctc;
        logic [2:0] cs;
    } atp_ctrl_t;

    typedef enum logic {ATP_UP, ATP_DOWN} atp_dir_t;

    // prescaler mask per clock select: tick when masked bits are all ones
    function automatic logic [9:0] atp_div_mask(input logic [2:0] cs);
        case (cs)
            3'h2:    atp_div_mask = 10'h007;
            3'h3:    atp_div_mask = 10'h01F;
            3'h4:    atp_div_mask = 10'h03F;
            3'h5:    atp_div_mask = 10'h07F;
            3'h6:    atp_div_mask = 10'h0FF;
            3'h7:    atp_div_mask = 10'h3FF;
            default: atp_div_mask = 10'h000;
        endcase
    endfunction

endpackage

// [verification/atp_timer_tb.sv]
// self-checking bench for the async 8-bit timer with pwm
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %0t mismatch got %h exp %h", $time, (g), (e)); end end
module async_8bit_timer_pwm_tb_top;
    import atp_pkg::*;
    // bench signals
    logic        sys_clk, rst, avs_read, avs_write, xtal, dir_out;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable;
    logic        avs_waitrequest, pin_o, pin_oe_n, claimed, ovf_irq, cmp_irq;
    int          n_fail, n_compared;
    logic [7:0]  rd;
    atp_timer atp_timer_inst (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .crystal_clock_pin(xtal),
        .port_dir_out(dir_out), .compare_output_pin_o(pin_o),
        .compare_output_pin_oe_n(pin_oe_n), .crystal_pins_claimed(claimed),
        .overflow_irq(ovf_irq), .compare_irq(cmp_irq));
    // 250 mhz clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic tally_and_finish;
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // one avalon transfer; request held until waitrequest is sampled low
    // only the watchdog ends a wait that never sees waitrequest low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        if (wr) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge sys_clk);
        end
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge sys_clk); // gap so a following request never lands in this step
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // reserved, read-only and select bits of the status register
    task automatic t_regs;
        bus(0, ASYNC_STATUS_IDX, 8'h00); `CHK(rd, 8'h00)
        avs_byteenable <= 4'hE;
        bus(1, ASYNC_STATUS_IDX, 8'hFF);
        avs_byteenable <= 4'hF;
        bus(0, ASYNC_STATUS_IDX, 8'h00); `CHK(rd, 8'h00)
        bus(1, ASYNC_STATUS_IDX, 8'hFF);
        bus(0, ASYNC_STATUS_IDX, 8'h00); `CHK(rd, 8'h08)
        cyc(2); `CHK(claimed, 1'b1)
        bus(1, ASYNC_STATUS_IDX, 8'h00);
        cyc(2); `CHK(claimed, 1'b0)
        bus(0, 8'h10, 8'h00); `CHK(rd, 8'h00)
        $display("test regs done");
    endtask
    // stop, write-equality without match, counted match, prescaler codes
    task automatic t_count;
        int dv [6] = '{8, 32, 64, 128, 256, 1024}; // divide ratios for codes 2..7
        bus(1, CONTROL_IDX, 8'h00);
        bus(1, COUNT_IDX, 8'h5A);
        bus(1, COMPARE_IDX, 8'h5A);
        cyc(10);
        bus(0, COUNT_IDX, 8'h00); `CHK(rd, 8'h5A)
        bus(0, FLAGS_IDX, 8'h00); `CHK(rd, 8'h00)
        bus(1, COMPARE_IDX, 8'h60);
        bus(1, CONTROL_IDX, 8'h01);
        cyc(20);
        bus(1, CONTROL_IDX, 8'h00);
        bus(0, FLAGS_IDX, 8'h00); `CHK(rd[1], 1'b1)
        bus(1, FLAGS_IDX, 8'h03);
        bus(0, FLAGS_IDX, 8'h00); `CHK(rd, 8'h00)
        // write equal to compare while running: resumes next tick, no match
        bus(1, CONTROL_IDX, 8'h01);
        bus(1, COUNT_IDX, 8'h60);
        bus(0, COUNT_IDX, 8'h00); `CHK(rd, 8'h61)
        bus(1, CONTROL_IDX, 8'h00);
        bus(0, FLAGS_IDX, 8'h00); `CHK(rd, 8'h00)
        for (int c = 2; c < 8; c++) begin
            bus(1, COUNT_IDX, 8'h00);
            bus(1, CONTROL_IDX, {5'h0, c[2:0]});
            cyc(4 * dv[c - 2]);
            bus(1, CONTROL_IDX, 8'h00);
            bus(0, COUNT_IDX, 8'h00); `CHK(rd >= 8'h03 && rd <= 8'h05, 1'b1)
        end
        bus(1, FLAGS_IDX, 8'h03);
        $display("test count done");
    endtask
    // pwm period, pin gating, forced levels, overflow interrupt
    task automatic t_pwm;
        int i, n;
        logic [7:0] tb [4][3];
        tb = '{'{8'h61, 8'h00, 8'h00}, '{8'h61, 8'hFF, 8'h01},
               '{8'h71, 8'h00, 8'h01}, '{8'h71, 8'hFF, 8'h00}};
        i = 0;
        n = 0;
        dir_out <= 1'b1;
        bus(1, COUNT_IDX, 8'h00);
        bus(1, COMPARE_IDX, 8'h80);
        bus(1, CONTROL_IDX, 8'h61);
        while (pin_o !== 1'b0 && i < 3000) begin @(posedge sys_clk); i++; end
        while (pin_o !== 1'b1 && i < 3000) begin @(posedge sys_clk); i++; end
        while (pin_o !== 1'b0 && n < 3000) begin @(posedge sys_clk); n++; end
        while (pin_o !== 1'b1 && n < 3000) begin @(posedge sys_clk); n++; end
        `CHK(n, PWM_PERIOD)
        `CHK(pin_oe_n, 1'b0)
        bus(1, COMPARE_IDX, 8'h40);
        bus(0, COMPARE_IDX, 8'h00); `CHK(rd, 8'h40)
        bus(1, IRQ_ENABLE_IDX, 8'h81);
        cyc(600); `CHK(ovf_irq, 1'b1)
        bus(1, IRQ_ENABLE_IDX, 8'h01);
        cyc(3); `CHK(ovf_irq, 1'b0)
        bus(1, IRQ_ENABLE_IDX, 8'h82);
        cyc(3); `CHK(cmp_irq, 1'b1)
        bus(1, IRQ_ENABLE_IDX, 8'h00);
        cyc(3); `CHK(cmp_irq, 1'b0)
        for (int k = 0; k < 4; k++) begin
            bus(1, CONTROL_IDX, tb[k][0]);
            bus(1, COMPARE_IDX, tb[k][1]);
            cyc(600); `CHK(pin_o, tb[k][2][0])
            cyc(200); `CHK(pin_o, tb[k][2][0])
        end
        dir_out <= 1'b0;
        cyc(4); `CHK(pin_oe_n, 1'b1)
        bus(1, CONTROL_IDX, 8'h00);
        bus(1, FLAGS_IDX, 8'h03);
        $display("test pwm done");
    endtask
    // crystal rising edge, slow against the cpu clock
    task automatic xtal_pulse;
        cyc(8);
        xtal <= 1'b1;
        cyc(8);
        xtal <= 1'b0;
        cyc(8);
    endtask
    // safe switch to the crystal, holding registers, busy flags over two crystal edges
    task automatic t_async;
        bus(1, IRQ_ENABLE_IDX, 8'h00);
        bus(1, ASYNC_STATUS_IDX, 8'h08);
        bus(1, COUNT_IDX, 8'h33);
        bus(1, COMPARE_IDX, 8'h44);
        bus(1, CONTROL_IDX, 8'h01);
        bus(0, ASYNC_STATUS_IDX, 8'h00); `CHK(rd, 8'h0F)
        bus(0, COMPARE_IDX, 8'h00); `CHK(rd, 8'h44)
        xtal_pulse();
        bus(0, ASYNC_STATUS_IDX, 8'h00); `CHK(rd, 8'h0F)
        xtal_pulse();
        bus(0, ASYNC_STATUS_IDX, 8'h00); `CHK(rd, 8'h08)
        bus(0, COUNT_IDX, 8'h00); `CHK(rd, 8'h33)
        xtal_pulse();
        bus(0, COUNT_IDX, 8'h00); `CHK(rd, 8'h34)
        bus(1, FLAGS_IDX, 8'h03);
        $display("test async done");
    endtask
    // mid-run reset brings outputs and registers back to idle
    task automatic t_reset;
        rst <= 1'b1;
        cyc(3);
        `CHK(avs_waitrequest, 1'b1)
        `CHK(avs_readdata, 32'h0)
        `CHK(pin_o, 1'b0)
        `CHK(pin_oe_n, 1'b1)
        `CHK(claimed, 1'b0)
        `CHK(ovf_irq, 1'b0)
        `CHK(cmp_irq, 1'b0)
        rst <= 1'b0;
        cyc(2);
        bus(0, ASYNC_STATUS_IDX, 8'h00); `CHK(rd, 8'h00)
        bus(0, COUNT_IDX, 8'h00); `CHK(rd, 8'h00)
        $display("test reset done");
    endtask
    // watchdog at nearly three times the expected run of some 11000 cycles
    initial begin
        #120000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        n_fail = 0;
        n_compared = 0;
        rst = 1'b1;
        {avs_read, avs_write, xtal, dir_out} = 4'h0;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        cyc(10);
        rst <= 1'b0;
        cyc(2);
        t_regs();
        t_count();
        t_pwm();
        t_async();
        t_reset();
        tally_and_finish();
    end
endmodule // async_8bit_timer_pwm_tb_top
